// [hdl/cycle_timer.v]
// Down counter that measures a number of whole clock cycles.
// Assumes load and count values within the counter width.
`timescale 1ns/10ps
`include "dpram_host_consts.vh"

module cycle_timer (
	// Clock and reset
	input wire sys_clk,
	input wire rst,
	// Control
	input wire load,
	input wire [`CNT_W-1:0] load_value,
	// Status
	output wire expired
);
	reg [`CNT_W-1:0] count_reg;
	reg [`CNT_W-1:0] count_next;

	// Load wins over counting so a new phase always starts fresh
	always @* begin
		count_next = count_reg;
		if (load)
			count_next = load_value;
		else if (count_reg != `CNT_ZERO)
			count_next = count_reg - `CNT_ONE;
	end

	// Counter register
	always @(posedge sys_clk or posedge rst) begin
		if (rst)
			count_reg <= `CNT_ZERO;
		else
			count_reg <= count_next;
	end

	// No load term: the state machine loads on expiry, which would close a loop
	assign expired = (count_reg <= `CNT_ONE);
endmodule // cycle_timer

// [hdl/dpram_port_host.v]
// Host controller for one port of an asynchronous dual-port memory.
// Assumes pins are sampled synchronously to sys_clk; data bus is split in/out/enable.
`timescale 1ns/10ps
`include "dpram_host_consts.vh"

// How it works
// - Address changes only with write high
// - Stretch pulse when output enable low
// - Array: select low; semaphore: sem select low
// - Keep chip select high across semaphore cycles
// - Hold write after busy release
// - Slave busy valid before write start
module dpram_port_host (
	// Clock and reset
	input wire sys_clk,
	input wire rst,
	// User request
	input wire req_valid,
	output wire req_ready,
	input wire req_write,
	input wire req_sem,
	input wire req_oe_during_write,
	input wire [`ADDR_W-1:0] req_addr,
	input wire [`DATA_W-1:0] req_wdata,
	// User answer
	output reg resp_valid,
	output reg [`DATA_W-1:0] resp_rdata,
	output reg resp_sem_owned,
	// Memory port pins
	output reg chip_select_n,
	output reg semaphore_select_n,
	output reg read_write_n,
	output reg output_enable_n,
	output reg upper_byte_select_n,
	output reg lower_byte_select_n,
	output reg [`ADDR_W-1:0] addr,
	output reg [`DATA_W-1:0] data_out,
	output reg data_oe,
	input wire [`DATA_W-1:0] data_in,
	input wire busy_n
);
	reg [2:0] state_reg;
	reg [2:0] state_next;
	reg write_reg;
	reg sem_reg;
	reg oe_reg;
	reg timer_load;
	reg [`CNT_W-1:0] timer_value;
	wire timer_expired;
	wire [`CNT_W-1:0] pulse_cycles;

	// State codes
	localparam [2:0] IDLE = `ST_IDLE;
	localparam [2:0] SETUP = `ST_SETUP;
	localparam [2:0] PULSE = `ST_PULSE;
	localparam [2:0] HOLD = `ST_HOLD;
	localparam [2:0] RECOVER = `ST_RECOVER;
	localparam [2:0] READ = `ST_READ;
	localparam [2:0] DONE = `ST_DONE;
	// Phase lengths sized to the timer, so no load value is cut silently
	localparam [`CNT_W-1:0] PULSE_CYC = `CYC_WRITE_PULSE;
	localparam [`CNT_W-1:0] PULSE_OE_CYC = (`CYC_WRITE_PULSE_OE > `CYC_WRITE_PULSE) ?
		`CYC_WRITE_PULSE_OE : `CYC_WRITE_PULSE;
	localparam [`CNT_W-1:0] HOLD_CYC = `CYC_HOLD_AFTER_BUSY;
	localparam [`CNT_W-1:0] GAP_CYC = `CYC_SEM_GAP;
	localparam [`CNT_W-1:0] READ_CYC = `CYC_READ;

	// Phase timer shared by all states
	cycle_timer u_timer (
		.sys_clk(sys_clk),
		.rst(rst),
		.load(timer_load),
		.load_value(timer_value),
		.expired(timer_expired)
	);

	assign req_ready = (state_reg == IDLE);
	// Output drivers must turn off before data setup counts
	assign pulse_cycles = oe_reg ? PULSE_OE_CYC : PULSE_CYC;

	// Next state and timer loading
	always @* begin
		state_next = state_reg;
		timer_load = 1'b0;
		timer_value = `CNT_ONE;
		case (state_reg)
			IDLE: begin
				if (req_valid) begin
					state_next = SETUP;
					timer_load = 1'b1;
				end
			end
			SETUP: begin
				// Address and selects settle with write high
				if (timer_expired) begin
					timer_load = 1'b1;
					if (write_reg) begin
						state_next = PULSE;
						timer_value = pulse_cycles;
					end else begin
						state_next = READ;
						timer_value = READ_CYC;
					end
				end
			end
			PULSE: begin
				// Busy low blocks the write, so keep the pulse open
				if (!busy_n) begin
					state_next = HOLD;
					timer_load = 1'b1;
					timer_value = HOLD_CYC;
				end else if (timer_expired) begin
					state_next = RECOVER;
					timer_load = 1'b1;
					timer_value = GAP_CYC;
				end
			end
			HOLD: begin
				// Restart the hold count while busy stays low
				if (!busy_n) begin
					timer_load = 1'b1;
					timer_value = HOLD_CYC;
				end else if (timer_expired) begin
					state_next = RECOVER;
					timer_load = 1'b1;
					timer_value = GAP_CYC;
				end
			end
			RECOVER: begin
				// Semaphore writes read back the flag to learn ownership
				if (timer_expired) begin
					if (sem_reg) begin
						state_next = READ;
						timer_load = 1'b1;
						timer_value = READ_CYC;
					end else
						state_next = DONE;
				end
			end
			READ: begin
				if (timer_expired)
					state_next = DONE;
			end
			DONE: state_next = IDLE;
			default: state_next = IDLE;
		endcase
	end

	// State, request latch and pin drive
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state_reg <= IDLE;
			write_reg <= 1'b0;
			sem_reg <= 1'b0;
			oe_reg <= 1'b0;
			chip_select_n <= 1'b1;
			semaphore_select_n <= 1'b1;
			read_write_n <= 1'b1;
			output_enable_n <= 1'b1;
			upper_byte_select_n <= 1'b1;
			lower_byte_select_n <= 1'b1;
			addr <= {`ADDR_W{1'b0}};
			data_out <= {`DATA_W{1'b0}};
			data_oe <= 1'b0;
			resp_valid <= 1'b0;
			resp_rdata <= {`DATA_W{1'b0}};
			resp_sem_owned <= 1'b0;
		end else begin
			state_reg <= state_next;
			resp_valid <= 1'b0;
			case (state_next)
				SETUP: begin
					if (state_reg == IDLE) begin
						// Address moves only while write is high
						write_reg <= req_write;
						sem_reg <= req_sem;
						oe_reg <= req_oe_during_write;
						addr <= req_addr;
						data_out <= req_wdata;
						// Chip select stays high for semaphores
						chip_select_n <= req_sem;
						semaphore_select_n <= !req_sem;
					end
					upper_byte_select_n <= 1'b0;
					lower_byte_select_n <= 1'b0;
					read_write_n <= 1'b1;
					output_enable_n <= 1'b1;
				end
				PULSE, HOLD: begin
					// Selects already low, so write low and host data drive start on the same edge
					read_write_n <= 1'b0;
					data_oe <= 1'b1;
					output_enable_n <= !oe_reg;
				end
				RECOVER: begin
					read_write_n <= 1'b1;
					data_oe <= 1'b0;
					output_enable_n <= 1'b1;
				end
				READ: begin
					read_write_n <= 1'b1;
					data_oe <= 1'b0;
					output_enable_n <= 1'b0;
				end
				DONE: begin
					resp_valid <= 1'b1;
					resp_rdata <= data_in;
					// Flag zero on bit zero means this port owns it
					resp_sem_owned <= sem_reg && !data_in[0];
					chip_select_n <= 1'b1;
					semaphore_select_n <= 1'b1;
					output_enable_n <= 1'b1;
					upper_byte_select_n <= 1'b1;
					lower_byte_select_n <= 1'b1;
					data_oe <= 1'b0;
				end
				default: begin
					read_write_n <= 1'b1;
					data_oe <= 1'b0;
				end
			endcase
		end
	end
endmodule // dpram_port_host

// [shared/dpram_host_consts.vh]
// Constants for the host-side controller of one port of a dual-port memory.
// Assumes a 250 MHz system clock; times are in ns, counts derived below.
`ifndef DPRAM_HOST_CONSTS_VH
`define DPRAM_HOST_CONSTS_VH

`define CLK_PERIOD_NS 4
// Write pulse minimum, output-off time, data setup, hold after busy release
`define T_WRITE_PULSE_NS 12
`define T_OUT_OFF_NS 10
`define T_DATA_SETUP_NS 10
`define T_HOLD_AFTER_BUSY_NS 12
`define T_SEM_WRITE_TO_READ_NS 5
`define T_READ_ACCESS_NS 15
// Least times round up to whole cycles
`define CYC_UP(ns) (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CYC_WRITE_PULSE `CYC_UP(`T_WRITE_PULSE_NS)
`define CYC_WRITE_PULSE_OE `CYC_UP(`T_OUT_OFF_NS + `T_DATA_SETUP_NS)
`define CYC_HOLD_AFTER_BUSY `CYC_UP(`T_HOLD_AFTER_BUSY_NS)
`define CYC_SEM_GAP `CYC_UP(`T_SEM_WRITE_TO_READ_NS)
`define CYC_READ `CYC_UP(`T_READ_ACCESS_NS)

`define ADDR_W 14
`define DATA_W 16
`define CNT_W 4
`define CNT_ZERO 4'h0
`define CNT_ONE 4'h1
`define SEM_ADDR_W 3

// Controller states
`define ST_IDLE 3'h0
`define ST_SETUP 3'h1
`define ST_PULSE 3'h2
`define ST_HOLD 3'h3
`define ST_RECOVER 3'h4
`define ST_READ 3'h5
`define ST_DONE 3'h6

`endif

// [testbench/dpram_host_chk.sv]
// Pin checker for the host side of one memory port.
// Assumes binding into the host controller, one clock domain.
`timescale 1ns/10ps
module dpram_host_chk (
	// Clock and reset
	input wire sys_clk,
	input wire rst,
	// Memory port pins
	input wire chip_select_n,
	input wire semaphore_select_n,
	input wire read_write_n,
	input wire output_enable_n,
	input wire upper_byte_select_n,
	input wire lower_byte_select_n,
	input wire [13:0] addr,
	input wire busy_n,
	// Host data drive
	input wire data_oe
);
	// One clock, so one default
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	property p_addr; !$stable(addr) |-> read_write_n || chip_select_n; endproperty
	a_addr: assert property (p_addr) else $error("addr moved in write");
	property p_pulse; $fell(read_write_n) |-> !read_write_n [*3]; endproperty
	a_pulse: assert property (p_pulse) else $error("short pulse");
	property p_pulse_oe; $fell(read_write_n) && !output_enable_n |-> !read_write_n [*5]; endproperty
	a_pulse_oe: assert property (p_pulse_oe) else $error("short pulse, oe low");
	property p_sel; !read_write_n |-> $stable({chip_select_n, semaphore_select_n}); endproperty
	a_sel: assert property (p_sel) else $error("select moved in write");
	property p_sem; !semaphore_select_n |-> chip_select_n; endproperty
	a_sem: assert property (p_sem) else $error("chip select low in sem");
	property p_hold; $rose(busy_n) && !read_write_n |-> !read_write_n [*3]; endproperty
	a_hold: assert property (p_hold) else $error("no hold after busy");
	property p_drive; data_oe |-> !read_write_n; endproperty
	a_drive: assert property (p_drive) else $error("data driven outside write");
	property p_bytes;
		!read_write_n && !chip_select_n |-> !upper_byte_select_n && !lower_byte_select_n;
	endproperty
	a_bytes: assert property (p_bytes) else $error("array write without bytes");
endmodule // dpram_host_chk
bind dpram_port_host dpram_host_chk dpram_host_chk_inst (
	.sys_clk(sys_clk), .rst(rst), .chip_select_n(chip_select_n),
	.semaphore_select_n(semaphore_select_n), .read_write_n(read_write_n),
	.output_enable_n(output_enable_n), .upper_byte_select_n(upper_byte_select_n),
	.lower_byte_select_n(lower_byte_select_n), .addr(addr), .busy_n(busy_n),
	.data_oe(data_oe)
);

// [testbench/dpram_model.sv]
// Model of one port of the dual-port memory, wired as a slave.
// Assumes pins move at sys_clk edges; the far port is reduced to far_hold.
`timescale 1ns/10ps
module dpram_model (
	// Clock
	input wire sys_clk,
	// Port pins
	input wire chip_select_n,
	input wire semaphore_select_n,
	input wire read_write_n,
	input wire output_enable_n,
	input wire upper_byte_select_n,
	input wire lower_byte_select_n,
	input wire [13:0] addr,
	input wire [15:0] data_out,
	input wire data_oe,
	input wire busy_n,
	output wire [15:0] data_in,
	// Far port owns every flag
	input wire far_hold
);
	reg [15:0] mem_reg [0:15];
	reg [7:0] mine_reg = 8'h00;
	reg [15:0] last_reg = 16'h0000;
	wire drive = read_write_n && !output_enable_n && chip_select_n != semaphore_select_n;
	// Written words show on the next edge, inside the port-to-port bound
	wire [15:0] q = chip_select_n ? {16{!mine_reg[addr[2:0]]}} : mem_reg[addr[3:0]];
	// Released bus shows the inverse so a stale word cannot pass
	assign data_in = drive ? q : ~last_reg;
	// A write the host does not drive lands corrupted
	wire [15:0] wd = data_oe ? data_out : ~data_out;
	// Busy low drops the write, as on a slave
	always @(posedge sys_clk) begin
		if (!read_write_n && busy_n) begin
			if (!chip_select_n && semaphore_select_n) begin
				if (!lower_byte_select_n) mem_reg[addr[3:0]][7:0] <= wd[7:0];
				if (!upper_byte_select_n) mem_reg[addr[3:0]][15:8] <= wd[15:8];
			end
			if (chip_select_n && !semaphore_select_n) mine_reg[addr[2:0]] <= !wd[0] && !far_hold;
		end
		last_reg <= data_in;
	end
endmodule // dpram_model

// [testbench/dpram_port_host_tb.sv]
// Bench for the host controller of one memory port.
// Assumes the memory model on the pins; busy is driven here.
`timescale 1ns/10ps
module dpram_port_host_tb;
	logic sys_clk = 1'b0, rst = 1'b1, req_valid = 1'b0, req_write = 1'b0, req_sem = 1'b0;
	logic req_oe_during_write = 1'b0, busy_n = 1'b1, far_hold = 1'b0;
	logic [13:0] req_addr = 14'h0000, addr;
	logic [15:0] req_wdata = 16'h0000, resp_rdata, data_out, data_in;
	logic req_ready, resp_valid, resp_sem_owned, chip_select_n, semaphore_select_n;
	logic read_write_n, output_enable_n, upper_byte_select_n, lower_byte_select_n, data_oe;
	int errors = 0, checks_done = 0, cyc = 0;
	dpram_port_host dpram_port_host_inst (
		.sys_clk(sys_clk), .rst(rst), .req_valid(req_valid), .req_ready(req_ready),
		.req_write(req_write), .req_sem(req_sem),
		.req_oe_during_write(req_oe_during_write), .req_addr(req_addr),
		.req_wdata(req_wdata), .resp_valid(resp_valid), .resp_rdata(resp_rdata),
		.resp_sem_owned(resp_sem_owned), .chip_select_n(chip_select_n),
		.semaphore_select_n(semaphore_select_n), .read_write_n(read_write_n),
		.output_enable_n(output_enable_n), .upper_byte_select_n(upper_byte_select_n),
		.lower_byte_select_n(lower_byte_select_n), .addr(addr), .data_out(data_out),
		.data_oe(data_oe), .data_in(data_in), .busy_n(busy_n)
	);
	dpram_model dpram_model_inst (
		.sys_clk(sys_clk), .chip_select_n(chip_select_n),
		.semaphore_select_n(semaphore_select_n), .read_write_n(read_write_n),
		.output_enable_n(output_enable_n), .upper_byte_select_n(upper_byte_select_n),
		.lower_byte_select_n(lower_byte_select_n), .addr(addr), .data_out(data_out),
		.data_oe(data_oe), .busy_n(busy_n), .data_in(data_in), .far_hold(far_hold)
	);
	// 250 MHz
	always #2 sys_clk = ~sys_clk;
	task check(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task results;
		$display("checks=%0d errors=%0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// One request, held until taken, then wait for the answer
	task op(input logic w, input logic s, input logic oe, input logic [13:0] a,
		input logic [15:0] d);
		int n;
		n = 0;
		@(posedge sys_clk);
		{req_valid, req_write, req_sem, req_oe_during_write, req_addr, req_wdata} <= {1'b1, w, s, oe, a, d};
		do @(posedge sys_clk); while (req_ready !== 1'b1);
		req_valid <= 1'b0;
		do begin
			@(posedge sys_clk);
			#1;
			n++;
		end while (resp_valid !== 1'b1 && n < 80);
		check({15'h0000, resp_valid}, 16'h0001);
	endtask
	task t_array;
		op(1'b1, 1'b0, 1'b1, 14'h0005, 16'hA5C3);
		op(1'b1, 1'b0, 1'b0, 14'h000A, 16'h3C5A);
		op(1'b0, 1'b0, 1'b0, 14'h0005, 16'h0000);
		check(resp_rdata, 16'hA5C3);
		op(1'b0, 1'b0, 1'b0, 14'h000A, 16'h0000);
		check(resp_rdata, 16'h3C5A);
		$display("test array done");
	endtask
	// Busy low must hold the write off, then it must complete
	task t_busy;
		@(posedge sys_clk);
		busy_n <= 1'b0;
		fork
			op(1'b1, 1'b0, 1'b0, 14'h0005, 16'h0F0F);
			begin
				repeat (12) @(posedge sys_clk);
				busy_n <= 1'b1;
			end
		join
		op(1'b0, 1'b0, 1'b0, 14'h0005, 16'h0000);
		check(resp_rdata, 16'h0F0F);
		$display("test busy done");
	endtask
	task t_sem;
		op(1'b1, 1'b1, 1'b0, 14'h0003, 16'h0000);
		check({15'h0000, resp_sem_owned}, 16'h0001);
		check(resp_rdata, 16'h0000);
		@(posedge sys_clk);
		far_hold <= 1'b1;
		op(1'b1, 1'b1, 1'b0, 14'h0005, 16'h0000);
		check({15'h0000, resp_sem_owned}, 16'h0000);
		check(resp_rdata, 16'hFFFF);
		@(posedge sys_clk);
		far_hold <= 1'b0;
		op(1'b1, 1'b1, 1'b0, 14'h0003, 16'h0001);
		check({15'h0000, resp_sem_owned}, 16'h0000);
		$display("test sem done");
	endtask
	// Hang guard, runs take about a hundred cycles
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 3000) begin
			errors++;
			results;
		end
	end
	initial begin
		repeat (3) @(posedge sys_clk);
		rst <= 1'b0;
		#1;
		check({12'h000, chip_select_n, semaphore_select_n, read_write_n, data_oe}, 16'h000E);
		t_array;
		t_busy;
		t_sem;
		results;
	end
endmodule // dpram_port_host_tb
